// ==== shared/adccr_map.vh ====
// Register map and field constants for the ADC control register segment.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ADCCR_MAP_VH
`define ADCCR_MAP_VH

// ==========================================================
// Register addresses
`define ADCCR_ADDR_DEC_HIGH   8'h1a
`define ADCCR_ADDR_DEC_LOW    8'h1b
`define ADCCR_ADDR_IDLE       8'h1c
`define ADCCR_ADDR_SYNC       8'h1d
`define ADCCR_ADDR_PIN_CTRL   8'h1e
`define ADCCR_ADDR_PIN_OUT    8'h1f
`define ADCCR_ADDR_PIN_IN     8'h20
`define ADCCR_ADDR_OFS_HIGH   8'h21

// ==========================================================
// Reset values
`define ADCCR_RST_ZERO        8'h00
`define ADCCR_RST_SYNC        8'h80
`define ADCCR_RST_RATIO       19'h00020
`define ADCCR_RST_STANDBY     10'h002

// ==========================================================
// Synchronization register fields
`define ADCCR_BIT_SW_START    7
`define ADCCR_BIT_EDGE_POS    6
`define ADCCR_BIT_PIN_START   3
`define ADCCR_RESET_ARM       2'b11
`define ADCCR_RESET_FIRE      2'b10

// ==========================================================
// Pin control register field and start pin index
`define ADCCR_BIT_GLOBAL_EN   7
`define ADCCR_PIN_START_IDX   3

// ==========================================================
// Arithmetic of derived settings
`define ADCCR_DEC_SHIFT       5
`define ADCCR_IDLE_SHIFT      1

`endif

// ==== src/adccr_segment.v ====
// ADC control register segment: decimation code, periodic idle time,
// sync and software reset control, and four general-purpose pins.
// Assumes a register port on clk fed by SPI framing logic, and raw
// pins and master clock arriving asynchronously.
//
// What this block does
// [R01] Ratio equals decimation code plus one times 32
// [R02] Upper five code bits in register below
// [R03] Standby idle equals idle field plus one doubled
// [R04] Host uses periodic mode only in slower modes
// [R05] Writing start bit zero gives one sync pulse
// [R06] Start bit returns to one by itself
// [R07] Edge select picks master clock edge for sync
// [R08] Pin-start: pin 3 low pulse makes sync
// [R09] Pin-start blocks pin access, forces others out
// [R10] Reset bits written 11 then 10 reset
// [R11] Pin settings change only while globally enabled
// [R12] Bits 6..4 make pins 2..0 open drain
// [R13] Bits 3..0 set pin directions, 1 output
// [R14] Output register low bits set pin levels
// [R15] Input register returns pin levels, ignores writes
// [R16] Sync register resets to 0x80
// [R17] Reserved bits read zero, ignore writes
// [R18] Output level reaches pin only when enabled, or on pins 2..0 in pin-start
`include "adccr_map.vh"

module adccr_segment (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  regAddr,
    input  wire        regWrite,
    input  wire [7:0]  regWrData,
    output reg  [7:0]  regRdData,
    input  wire        mclkPin,
    input  wire [3:0]  pinIn,
    output reg  [3:0]  pinOut,
    output reg  [3:0]  pinOe,
    output wire        syncOutN,
    output reg  [18:0] decimationRatio,
    output reg  [9:0]  standbyPeriods,
    output reg         softResetPulse
);

    // ==========================================================
    // Address decode helper for the write strobes; the read mux decodes with its own case
    function addrHit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addrHit = (addr == target);
        end
    endfunction

    wire wrDecHigh = regWrite && addrHit(regAddr, `ADCCR_ADDR_DEC_HIGH);
    wire wrDecLow  = regWrite && addrHit(regAddr, `ADCCR_ADDR_DEC_LOW);
    wire wrIdle    = regWrite && addrHit(regAddr, `ADCCR_ADDR_IDLE);
    wire wrSync    = regWrite && addrHit(regAddr, `ADCCR_ADDR_SYNC);
    wire wrPinCtrl = regWrite && addrHit(regAddr, `ADCCR_ADDR_PIN_CTRL);
    wire wrPinOut  = regWrite && addrHit(regAddr, `ADCCR_ADDR_PIN_OUT);
    wire wrOfsHigh = regWrite && addrHit(regAddr, `ADCCR_ADDR_OFS_HIGH);

    // ==========================================================
    // Storage
    reg  [4:0] decCodeHigh;
    reg  [7:0] decCodeLow;
    reg  [7:0] idleTime;
    reg  [7:0] offsetHigh;
    reg        swStartIdle;
    reg        edgePos;
    reg        pinStartEn;
    reg  [1:0] resetBits;
    reg        resetArmed;
    reg        globalPinEnable;
    reg  [2:0] pinOpenDrain;
    reg  [3:0] pinDirOut;
    reg  [3:0] pinLevel;

    // ==========================================================
    // Input synchronisers: master clock and pins pass two flops
    reg  [3:0] pinMeta;
    reg  [3:0] pinSync;
    reg        pin3Prev;
    reg        mclkMeta;
    reg        mclkSync;
    reg        mclkPrev;

    // Third stage only feeds edge detection, never the first stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta  <= 4'hf; // Pull-up idle level, no false start edge
            pinSync  <= 4'hf;
            pin3Prev <= 1'b1;
            mclkMeta <= 1'b0;
            mclkSync <= 1'b0;
            mclkPrev <= 1'b0;
        end else begin
            pinMeta  <= pinIn;
            pinSync  <= pinMeta;
            pin3Prev <= pinSync[`ADCCR_PIN_START_IDX];
            mclkMeta <= mclkPin;
            mclkSync <= mclkMeta;
            mclkPrev <= mclkSync;
        end
    end

    wire mclkRise = mclkSync && !mclkPrev;
    wire mclkFall = !mclkSync && mclkPrev;

    // Low pulse on the start pin is caught on its falling edge
    wire pinStartFall = pinStartEn && pin3Prev &&
                        !pinSync[`ADCCR_PIN_START_IDX]; // R08

    // ==========================================================
    // Sync pulse requests
    wire swTrigger = wrSync && !regWrData[`ADCCR_BIT_SW_START]; // R05
    wire pulseDone;

    adccr_sync_pulse u_pulse (
        .clk        (clk),
        .rst_b      (rst_b),
        .clear      (softResetPulse),
        .trigger    (swTrigger || pinStartFall), // R05 R08
        .usePosEdge (edgePos), // R07
        .mclkRise   (mclkRise),
        .mclkFall   (mclkFall),
        .syncOutN   (syncOutN),
        .pulseDone  (pulseDone)
    );

    // ==========================================================
    // Decimation, idle and offset registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            decCodeHigh <= 5'h00;
            decCodeLow  <= `ADCCR_RST_ZERO;
            idleTime    <= `ADCCR_RST_ZERO;
            offsetHigh  <= `ADCCR_RST_ZERO;
        end else if (softResetPulse) begin
            decCodeHigh <= 5'h00;
            decCodeLow  <= `ADCCR_RST_ZERO;
            idleTime    <= `ADCCR_RST_ZERO;
            offsetHigh  <= `ADCCR_RST_ZERO;
        end else begin
            if (wrDecHigh) begin
                decCodeHigh <= regWrData[4:0]; // R02 R17
            end
            if (wrDecLow) begin
                decCodeLow <= regWrData;
            end
            if (wrIdle) begin
                idleTime <= regWrData;
            end
            if (wrOfsHigh) begin
                offsetHigh <= regWrData;
            end
        end
    end

    // ==========================================================
    // Derived settings, registered so outputs come from flops
    wire [13:0] decPlusOne  = {1'b0, decCodeHigh, decCodeLow} + 14'h0001;
    wire [8:0]  idlePlusOne = {1'b0, idleTime} + 9'h001;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            decimationRatio <= `ADCCR_RST_RATIO;
            standbyPeriods  <= `ADCCR_RST_STANDBY;
        end else begin
            decimationRatio <= {decPlusOne, {`ADCCR_DEC_SHIFT{1'b0}}}; // R01
            standbyPeriods  <= {idlePlusOne, {`ADCCR_IDLE_SHIFT{1'b0}}}; // R03
        end
    end

    // ==========================================================
    // Sync and software reset register
    // Start bit reads zero from the request until the next pulse ends; a new
    // request in the cycle the pulse ends keeps it low (set wins)
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            swStartIdle    <= 1'b1; // R16
            edgePos        <= 1'b0;
            pinStartEn     <= 1'b0;
            resetBits      <= 2'b00;
            resetArmed     <= 1'b0;
            softResetPulse <= 1'b0;
        end else if (softResetPulse) begin
            swStartIdle    <= 1'b1; // R16
            edgePos        <= 1'b0;
            pinStartEn     <= 1'b0;
            resetBits      <= 2'b00;
            resetArmed     <= 1'b0;
            softResetPulse <= 1'b0;
        end else begin
            if (swTrigger) begin
                swStartIdle <= 1'b0;
            end else if (pulseDone) begin
                swStartIdle <= 1'b1; // R06
            end
            if (wrSync) begin
                edgePos    <= regWrData[`ADCCR_BIT_EDGE_POS]; // R07
                pinStartEn <= regWrData[`ADCCR_BIT_PIN_START]; // R08
                resetBits  <= regWrData[1:0];
                // Only the reset pair matters, other bits are free
                resetArmed <= (regWrData[1:0] == `ADCCR_RESET_ARM); // R10
            end
            softResetPulse <= wrSync && resetArmed &&
                              (regWrData[1:0] == `ADCCR_RESET_FIRE); // R10
        end
    end

    // ==========================================================
    // Pin control and output level registers
    // Enable bit is always writable; the other fields follow only
    // when enable is already set or set by the same write
    wire pinCtrlOpen = globalPinEnable ||
                       regWrData[`ADCCR_BIT_GLOBAL_EN];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            globalPinEnable <= 1'b0;
            pinOpenDrain    <= 3'h0;
            pinDirOut       <= 4'h0;
            pinLevel        <= 4'h0;
        end else if (softResetPulse) begin
            globalPinEnable <= 1'b0;
            pinOpenDrain    <= 3'h0;
            pinDirOut       <= 4'h0;
            pinLevel        <= 4'h0;
        end else begin
            if (wrPinCtrl) begin
                globalPinEnable <= regWrData[`ADCCR_BIT_GLOBAL_EN];
                if (pinCtrlOpen) begin
                    pinOpenDrain <= regWrData[6:4]; // R11 R12
                    pinDirOut    <= regWrData[3:0]; // R11 R13
                end
            end
            // Level writes blocked while disabled or in pin-start
            if (wrPinOut && globalPinEnable && !pinStartEn) begin
                pinLevel <= regWrData[3:0]; // R09 R11 R14 R17
            end
        end
    end

    // ==========================================================
    // Pin drivers: pin 3 is push-pull only
    wire [3:0] openDrainSel = {1'b0, pinOpenDrain};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            wire drives;
            // Pin-start takes pin 3 as input and forces the rest out
            if (gi == `ADCCR_PIN_START_IDX) begin : g_start
                assign drives = !pinStartEn && globalPinEnable &&
                                pinDirOut[gi]; // R09 R13 R18
            end else begin : g_plain
                assign drives = pinStartEn ||
                                (globalPinEnable && pinDirOut[gi]); // R09
            end

            // Open drain only ever pulls low; high is released
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pinOut[gi] <= 1'b0;
                    pinOe[gi]  <= 1'b0;
                end else if (openDrainSel[gi]) begin
                    pinOut[gi] <= 1'b0; // R12
                    pinOe[gi]  <= drives && !pinLevel[gi]; // R12 R18
                end else begin
                    pinOut[gi] <= pinLevel[gi]; // R14
                    pinOe[gi]  <= drives; // R18
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read data, one cycle after the address; unmapped reads zero
    // Input levels are hidden while pin-start owns the pins
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= `ADCCR_RST_ZERO;
        end else begin
            case (regAddr)
                `ADCCR_ADDR_DEC_HIGH: begin
                    regRdData <= {3'h0, decCodeHigh}; // R17
                end
                `ADCCR_ADDR_DEC_LOW: begin
                    regRdData <= decCodeLow;
                end
                `ADCCR_ADDR_IDLE: begin
                    regRdData <= idleTime;
                end
                `ADCCR_ADDR_SYNC: begin
                    regRdData <= {swStartIdle, edgePos, 2'b00,
                                  pinStartEn, 1'b0, resetBits}; // R17
                end
                `ADCCR_ADDR_PIN_CTRL: begin
                    regRdData <= {globalPinEnable, pinOpenDrain,
                                  pinDirOut};
                end
                `ADCCR_ADDR_PIN_OUT: begin
                    regRdData <= {4'h0, pinLevel}; // R17
                end
                `ADCCR_ADDR_PIN_IN: begin
                    regRdData <= pinStartEn ? `ADCCR_RST_ZERO :
                                 {4'h0, pinSync}; // R09 R15
                end
                `ADCCR_ADDR_OFS_HIGH: begin
                    regRdData <= offsetHigh;
                end
                default: begin
                    regRdData <= `ADCCR_RST_ZERO;
                end
            endcase
        end
    end

endmodule // adccr_segment

// ==== src/adccr_sync_pulse.v ====
// Sync output pulse generator: one low pulse per request, or one for all requests
// made during a pulse; one master clock period long, aligned to the selected master clock edge.
// Assumes edge strobes already come from synchronised master clock.
module adccr_sync_pulse (
    input  wire clk,
    input  wire rst_b,
    input  wire clear,
    input  wire trigger,
    input  wire usePosEdge,
    input  wire mclkRise,
    input  wire mclkFall,
    output reg  syncOutN,
    output reg  pulseDone
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_LOW  = 2'b10;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        pending;
    wire       driveEdge;

    // Chosen master clock edge times both the fall and rise of the pulse
    assign driveEdge = usePosEdge ? mclkRise : mclkFall; // R07

    // ==========================================================
    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trigger || pending) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (driveEdge) begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (driveEdge) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State, pending request and pin
    // A trigger during a pulse is held in one pending flag; further triggers merge into it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            pending   <= 1'b0;
            syncOutN  <= 1'b1;
            pulseDone <= 1'b0;
        end else if (clear) begin
            state     <= ST_IDLE;
            pending   <= 1'b0;
            syncOutN  <= 1'b1;
            pulseDone <= 1'b0;
        end else begin
            state     <= next_state;
            if (trigger && state != ST_IDLE) begin
                pending <= 1'b1;
            end else if (state == ST_IDLE) begin
                pending <= 1'b0;
            end
            if (state == ST_WAIT && driveEdge) begin
                syncOutN <= 1'b0; // R05
            end else if (state == ST_LOW && driveEdge) begin
                syncOutN <= 1'b1;
            end
            pulseDone <= (state == ST_LOW) && driveEdge;
        end
    end

endmodule // adccr_sync_pulse

// ==== testbench/adccr_pin_env.sv ====
// Board model: free master clock and the four pins with pull-ups.
// Assumes the bench drives a pin that the device drives only until the device releases it.
module adccr_pin_env (
    input  logic [3:0] pinOut,
    input  logic [3:0] pinOe,
    input  logic [3:0] extDrive,
    input  logic [3:0] extVal,
    output logic [3:0] pinIn,
    output logic       mclkPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Master clock runs free, phase unrelated to the system clock
    initial begin
        mclkPin = 1'b0;
        #13;
        forever #80 mclkPin = ~mclkPin;
    end
    // Device drive wins, then outside driver, else pull-up high
    assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extVal)
        | (~pinOe & ~extDrive);
endmodule // adccr_pin_env

// ==== testbench/adccr_segment_sva.sv ====
// Port checker for the ADC control register segment.
// Assumes bind onto adccr_segment and a 160 ns master clock.
`include "adccr_map.vh"
module adccr_segment_chk (
    input logic        clk,
    input logic        rst_b,
    input logic [7:0]  regAddr,
    input logic        regWrite,
    input logic [7:0]  regWrData,
    input logic [7:0]  regRdData,
    input logic        mclkPin,
    input logic [3:0]  pinIn,
    input logic [3:0]  pinOut,
    input logic [3:0]  pinOe,
    input logic        syncOutN,
    input logic [18:0] decimationRatio,
    input logic [9:0]  standbyPeriods,
    input logic        softResetPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // =========
    // Steps of the reset pair
    sequence sArm;
        regWrite && regAddr == `ADCCR_ADDR_SYNC && regWrData[1:0] == 2'b11;
    endsequence
    sequence sFire;
        regWrite && regAddr == `ADCCR_ADDR_SYNC && regWrData[1:0] == 2'b10;
    endsequence
    // =========
    // Assertions
    // A gap cycle with no sync write between the two steps keeps the pair armed
    chk_reset_pair: assert property (sArm ##1
        !(regWrite && regAddr == `ADCCR_ADDR_SYNC) ##1 sFire
        |=> softResetPulse)
        else $error("reset pair gave no reset pulse");
    chk_reset_cause: assert property (softResetPulse |->
        $past(regWrite && regAddr == 8'h1d && regWrData[1:0] == 2'b10))
        else $error("reset pulse without a reset pair");
    chk_ratio_calc: assert property (regWrite && regAddr == 8'h1b
        |-> ##2 decimationRatio[12:5] == $past(regWrData, 2) + 8'h01)
        else $error("decimation ratio wrong");
    chk_idle_calc: assert property (regWrite && regAddr == 8'h1c
        |-> ##2 standbyPeriods == {$past(regWrData, 2) + 9'h001, 1'b0})
        else $error("standby periods wrong");
    // Low at least 8 cycles, high again 32 to 47 cycles after the fall; one master clock period is 40
    chk_sync_width: assert property ($fell(syncOutN)
        |-> !syncOutN [*8] ##[25:40] syncOutN)
        else $error("sync pulse width wrong");
    chk_sync_start: assert property (regWrite && regAddr == 8'h1d
        && !regWrData[7] |-> ##[1:120] !syncOutN)
        else $error("software start gave no sync pulse");
    chk_unmapped_zero: assert property (regAddr < 8'h1a
        || regAddr > 8'h21 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property ((regAddr == 8'h1f
        || regAddr == 8'h20) |=> regRdData[7:4] == 4'h0)
        else $error("reserved pin bits not zero");
    // Enables only move after a write or a soft reset
    chk_oe_cause: assert property ($changed(pinOe) |->
        $past(regWrite) || $past(regWrite, 2) ||
        $past(softResetPulse) || $past(softResetPulse, 2))
        else $error("pin enable changed without cause");
endmodule // adccr_segment_chk

bind adccr_segment adccr_segment_chk i_adccr_segment_chk (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRdData(regRdData), .mclkPin(mclkPin),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .syncOutN(syncOutN),
    .decimationRatio(decimationRatio), .standbyPeriods(standbyPeriods),
    .softResetPulse(softResetPulse));

// ==== testbench/testbench.sv ====
// Self-checking bench for the ADC control register segment.
// Assumes the design and pin model files are compiled before it.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_b;
    logic [7:0]  regAddr;
    logic        regWrite;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    logic        mclkPin;
    logic [3:0]  pinIn;
    logic [3:0]  pinOut;
    logic [3:0]  pinOe;
    logic        syncOutN;
    logic [18:0] decimationRatio;
    logic [9:0]  standbyPeriods;
    logic        softResetPulse;
    logic [3:0]  extDrive;
    logic [3:0]  extVal;
    int          n_fail;
    int          checks;
    int          nRst;
    int          w;
    logic [7:0]  rstTab [0:8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                                  8'h00, 8'h0f, 8'h00, 8'h00};

    adccr_segment i_adccr_segment (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .mclkPin(mclkPin),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .syncOutN(syncOutN),
        .decimationRatio(decimationRatio), .standbyPeriods(standbyPeriods),
        .softResetPulse(softResetPulse));
    adccr_pin_env i_adccr_pin_env (
        .pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
        .extVal(extVal), .pinIn(pinIn), .mclkPin(mclkPin));

    // =========
    // Clock and reset pulse counter
    always #2 clk = ~clk;
    always @(negedge clk) begin
        if (softResetPulse === 1'b1) nRst++;
    end

    // =========
    // Access tasks
    task cmp(input logic [18:0] seen, input logic [18:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    // Read data lands one cycle after the address
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        cmp(regRdData, exp);
    endtask
    task end_of_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait; n counts falling edges until the level shows
    task waitSync(input logic lvl, output int n);
        n = 0;
        while (syncOutN !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            n_fail++;
            end_of_test();
        end
    endtask

    // =========
    // Main sequence
    initial begin
        {clk, rst_b, regAddr, regWrite, regWrData} = '0;
        {extDrive, extVal, n_fail, checks, nRst} = '0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 9; i++) rd(8'h1a + i[7:0], rstTab[i]);
        wr(8'h1b, 8'hff);
        wr(8'h1a, 8'hff);
        rd(8'h1a, 8'h1f);
        cmp(decimationRatio, 19'h40000);
        wr(8'h1c, 8'hff);
        rd(8'h1c, 8'hff);
        cmp(standbyPeriods, 19'd512);
        wr(8'h20, 8'h00);
        wr(8'h22, 8'h55);
        rd(8'h20, 8'h0f);
        rd(8'h22, 8'h00);
        // Pin settings refused until the global enable is up
        wr(8'h1e, 8'h0f);
        rd(8'h1e, 8'h00);
        wr(8'h1e, 8'h8f);
        wr(8'h1f, 8'hfa);
        rd(8'h1f, 8'h0a);
        cmp(pinOe, 4'hf);
        cmp(pinOut, 4'ha);
        // Open drain on pins 0..2, pins 2 and 3 driven from outside
        extDrive = 4'hc;
        extVal = 4'h4;
        wr(8'h1e, 8'hf3);
        repeat (6) @(negedge clk);
        cmp(pinOe, 4'h1);
        cmp(pinOut[2:0], 3'h0);
        rd(8'h20, 8'h06);
        // Pin-start: pin 3 becomes the start input
        wr(8'h1e, 8'h80);
        extDrive = 4'h8;
        extVal = 4'hc;
        wr(8'h1d, 8'h88);
        repeat (6) @(negedge clk);
        cmp(pinOe, 4'h7);
        cmp(pinOut[2:0], 3'h2);
        rd(8'h20, 8'h00);
        wr(8'h1f, 8'h05);
        rd(8'h1f, 8'h0a);
        extVal = 4'h4;
        waitSync(1'b0, w);
        extVal = 4'hc;
        waitSync(1'b1, w);
        cmp(w, 19'd40);
        // Software start on each master clock edge
        wr(8'h1d, 8'h80);
        for (int e = 0; e < 2; e++) begin
            wr(8'h1d, {1'b0, e[0], 6'h00});
            waitSync(1'b0, w);
            cmp(mclkPin, e[0]);
            rd(8'h1d, {1'b0, e[0], 6'h00});
            waitSync(1'b1, w);
            repeat (3) @(negedge clk);
            rd(8'h1d, {1'b1, e[0], 6'h00});
        end
        // An interrupted pair must not reset; a clean pair must
        wr(8'h1b, 8'h07);
        wr(8'h1d, 8'h83);
        wr(8'h1d, 8'h80);
        wr(8'h1d, 8'h82);
        rd(8'h1b, 8'h07);
        cmp(nRst, 19'd0);
        wr(8'h1d, 8'h83);
        wr(8'h1d, 8'h82);
        repeat (3) @(negedge clk);
        rd(8'h1b, 8'h00);
        rd(8'h1c, 8'h00);
        cmp(decimationRatio, 19'h20);
        cmp(nRst, 19'd1);
        end_of_test();
    end
endmodule // testbench
